// *** rim_axil_slave.sv ***
// axi4-lite slave front end for the receiver interrupt registers
`timescale 1ns/1ps
`include "rim_cfg.svh"
module rim_axil_slave (
    // clock and reset
    input  wire logic                clk,
    input  wire logic                rst,
    // write address and data
    input  wire logic [`RIM_AW-1:0]  awaddr,
    input  wire logic                awvalid,
    output logic                     awready,
    input  wire logic [31:0]         wdata,
    input  wire logic [3:0]          wstrb,
    input  wire logic                wvalid,
    output logic                     wready,
    // write response
    output logic [1:0]               bresp,
    output logic                     bvalid,
    input  wire logic                bready,
    // read
    input  wire logic [`RIM_AW-1:0]  araddr,
    input  wire logic                arvalid,
    output logic                     arready,
    output logic [31:0]              rdata,
    output logic [1:0]               rresp,
    output logic                     rvalid,
    input  wire logic                rready,
    // register file side
    output rim_pkg::rim_wr_type      wr,
    output logic [7:0]               rd_idx,
    input  wire logic [7:0]          rd_data
);
    import rim_pkg::*;

    function automatic logic reg_hit(input logic [`RIM_AW-1:0] a);
        logic [7:0] i;
        i = a[`RIM_AW-1:`RIM_IDX_LSB];
        reg_hit = (i == `RIM_IDX_EN_ONE) || (i == `RIM_IDX_EN_TWO) || (i == `RIM_IDX_TRIG_ONE) ||
                  (i == `RIM_IDX_STS_ONE) || (i == `RIM_IDX_STS_TWO) || (i == `RIM_IDX_CLR_ONE) ||
                  (i == `RIM_IDX_CLR_TWO) || (i == `RIM_IDX_COND);
    endfunction : reg_hit

    logic [`RIM_AW-1:0] awaddr_r, awaddr_nxt;
    logic [7:0]         wdata_r, wdata_nxt;
    logic               wlane_r, wlane_nxt;
    logic               aw_full_r, aw_full_nxt, w_full_r, w_full_nxt;
    logic               bvalid_r, bvalid_nxt, rvalid_r, rvalid_nxt;
    logic [1:0]         bresp_r, bresp_nxt, rresp_r, rresp_nxt;
    logic [31:0]        rdata_r, rdata_nxt;
    logic               awready_r, awready_nxt, wready_r, wready_nxt, arready_r, arready_nxt;
    logic               commit;

    assign rd_idx = araddr[`RIM_AW-1:`RIM_IDX_LSB];

    always_comb begin
        awaddr_nxt  = awaddr_r;
        wdata_nxt   = wdata_r;
        wlane_nxt   = wlane_r;
        aw_full_nxt = aw_full_r;
        w_full_nxt  = w_full_r;
        bvalid_nxt  = bvalid_r;
        bresp_nxt   = bresp_r;
        // address and data are held separately, so either may arrive first
        if (awvalid && awready_r) begin
            awaddr_nxt  = awaddr;
            aw_full_nxt = 1'b1;
        end
        if (wvalid && wready_r) begin
            wdata_nxt  = wdata[7:0];
            wlane_nxt  = wstrb[0];
            w_full_nxt = 1'b1;
        end
        commit = aw_full_r && w_full_r && !bvalid_r;
        if (commit) begin
            aw_full_nxt = 1'b0;
            w_full_nxt  = 1'b0;
            bvalid_nxt  = 1'b1;
            bresp_nxt   = reg_hit(awaddr_r) ? `RIM_RESP_OKAY : `RIM_RESP_SLVERR;
        end else if (bvalid_r && bready) begin
            bvalid_nxt = 1'b0;
        end
        awready_nxt = !aw_full_nxt;
        wready_nxt  = !w_full_nxt;
        // narrow registers live in lane 0; other lanes are dropped
        wr.en   = commit && reg_hit(awaddr_r) && wlane_r;
        wr.idx  = awaddr_r[`RIM_AW-1:`RIM_IDX_LSB];
        wr.data = wdata_r;
        rvalid_nxt = rvalid_r && !rready;
        rdata_nxt  = rdata_r;
        rresp_nxt  = rresp_r;
        if (arvalid && arready_r) begin
            rvalid_nxt = 1'b1;
            rdata_nxt  = reg_hit(araddr) ? {24'h000000, rd_data} : 32'h00000000;
            rresp_nxt  = reg_hit(araddr) ? `RIM_RESP_OKAY : `RIM_RESP_SLVERR;
        end
        arready_nxt = !rvalid_nxt;
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            awaddr_r  <= '0;
            wdata_r   <= 8'h00;
            wlane_r   <= 1'b0;
            aw_full_r <= 1'b0;
            w_full_r  <= 1'b0;
            bvalid_r  <= 1'b0;
            bresp_r   <= `RIM_RESP_OKAY;
            rvalid_r  <= 1'b0;
            rdata_r   <= 32'h00000000;
            rresp_r   <= `RIM_RESP_OKAY;
            awready_r <= 1'b1;
            wready_r  <= 1'b1;
            arready_r <= 1'b1;
        end else begin
            awaddr_r  <= awaddr_nxt;
            wdata_r   <= wdata_nxt;
            wlane_r   <= wlane_nxt;
            aw_full_r <= aw_full_nxt;
            w_full_r  <= w_full_nxt;
            bvalid_r  <= bvalid_nxt;
            bresp_r   <= bresp_nxt;
            rvalid_r  <= rvalid_nxt;
            rdata_r   <= rdata_nxt;
            rresp_r   <= rresp_nxt;
            awready_r <= awready_nxt;
            wready_r  <= wready_nxt;
            arready_r <= arready_nxt;
        end
    end

    assign awready = awready_r;
    assign wready  = wready_r;
    assign bvalid  = bvalid_r;
    assign bresp   = bresp_r;
    assign arready = arready_r;
    assign rvalid  = rvalid_r;
    assign rdata   = rdata_r;
    assign rresp   = rresp_r;

    property p_bhold;
        @(posedge clk) disable iff (rst)
        (bvalid_r && !bready) |=> (bvalid_r && $stable(bresp_r));
    endproperty
    a_bhold: assert property (p_bhold) else $error("write response dropped before bready");
endmodule : rim_axil_slave

// *** rim_cfg.svh ***
// constants for the receiver interrupt mask and mode block
// What this block does
// - channel status crc interrupt enabled only when set
// - parity error interrupt gated by its enable
// - validity error interrupt gated by its enable
// - biphase error interrupt gated by its enable
// - subcode change interrupt gated by its enable
// - lock loss interrupt gated by its enable
// - subcode crc interrupt gated by its enable
// - buffer transfer interrupt gated by its enable
// - output slip interrupt gated by second enable
// - subcode change trigger: rise, fall, level
// - lock loss trigger: rise, fall, level
// - subcode crc trigger: rise, fall, level
// - buffer transfer trigger from mode bits 1:0
// - no interrupt without its enable bit set
`ifndef RIM_CFG_SVH
`define RIM_CFG_SVH

// register indices; byte address is four times the index
`define RIM_IDX_EN_ONE   8'h16
`define RIM_IDX_EN_TWO   8'h17
`define RIM_IDX_TRIG_ONE 8'h18
`define RIM_IDX_STS_ONE  8'h30
`define RIM_IDX_STS_TWO  8'h31
`define RIM_IDX_CLR_ONE  8'h32
`define RIM_IDX_CLR_TWO  8'h33
`define RIM_IDX_COND     8'h34

// bus geometry
`define RIM_AW           10
`define RIM_IDX_LSB      2
`define RIM_RESP_OKAY    2'h0
`define RIM_RESP_SLVERR  2'h2

// source positions: bits 7..0 follow enable one, bit 8 is the slip source
`define RIM_NSRC         9
`define RIM_NMODE        4
`define RIM_SRC_SLIP     8
`define RIM_SRC_CSCRC    7
`define RIM_SRC_PARITY   6
`define RIM_SRC_VALID    5
`define RIM_SRC_BIPH     4
`define RIM_SRC_QCHG     3
`define RIM_SRC_LOCK     2
`define RIM_SRC_QCRC     1
`define RIM_SRC_XFER     0

// reset values
`define RIM_EN_RST       9'h000
`define RIM_TRIG_RST     8'h00
`define RIM_STS_RST      9'h000

`endif

// *** rim_pkg.sv ***
// types shared by the receiver interrupt block
package rim_pkg;
    typedef enum logic [1:0] {
        RIM_RISE  = 2'h0,
        RIM_FALL  = 2'h1,
        RIM_LEVEL = 2'h2,
        RIM_RSVD  = 2'h3
    } rim_mode_type;

    typedef struct packed {
        logic       en;
        logic [7:0] idx;
        logic [7:0] data;
    } rim_wr_type;
endpackage : rim_pkg

// *** rim_top.sv ***
// receiver interrupt mask, trigger mode and sticky status with axi4-lite access
`timescale 1ns/1ps
`include "rim_cfg.svh"
module rim_top (
    // clock and reset
    input  wire logic                   MCLK,
    input  wire logic                   RESET,
    // axi4-lite write address and data
    input  wire logic [`RIM_AW-1:0]     AWADDR,
    input  wire logic                   AWVALID,
    output logic                        AWREADY,
    input  wire logic [31:0]            WDATA,
    input  wire logic [3:0]             WSTRB,
    input  wire logic                   WVALID,
    output logic                        WREADY,
    // axi4-lite write response
    output logic [1:0]                  BRESP,
    output logic                        BVALID,
    input  wire logic                   BREADY,
    // axi4-lite read
    input  wire logic [`RIM_AW-1:0]     ARADDR,
    input  wire logic                   ARVALID,
    output logic                        ARREADY,
    output logic [31:0]                 RDATA,
    output logic [1:0]                  RRESP,
    output logic                        RVALID,
    input  wire logic                   RREADY,
    // receiver conditions, same clock, bit order as the status registers
    input  wire logic [`RIM_NSRC-1:0]   RX_COND,
    // interrupt request, active high level
    output logic                        RECV_IRQ
);
    import rim_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    // register bus

    rim_wr_type                  wr;
    logic [7:0]                  rd_idx;
    logic [7:0]                  rd_data;

    rim_axil_slave u_bus (
        .clk     (MCLK),
        .rst     (RESET),
        .awaddr  (AWADDR),
        .awvalid (AWVALID),
        .awready (AWREADY),
        .wdata   (WDATA),
        .wstrb   (WSTRB),
        .wvalid  (WVALID),
        .wready  (WREADY),
        .bresp   (BRESP),
        .bvalid  (BVALID),
        .bready  (BREADY),
        .araddr  (ARADDR),
        .arvalid (ARVALID),
        .arready (ARREADY),
        .rdata   (RDATA),
        .rresp   (RRESP),
        .rvalid  (RVALID),
        .rready  (RREADY),
        .wr      (wr),
        .rd_idx  (rd_idx),
        .rd_data (rd_data)
    );

    ////////////////////////////////////////////////////////////////////////////
    // state

    logic [`RIM_NSRC-1:0]        en_r;
    logic [`RIM_NSRC-1:0]        en_nxt;
    logic [7:0]                  trig_r;
    logic [7:0]                  trig_nxt;
    logic [`RIM_NSRC-1:0]        sts_r;
    logic [`RIM_NSRC-1:0]        sts_nxt;
    logic                        irq_r;
    logic                        irq_nxt;
    logic [`RIM_NSRC-1:0]        evt;
    logic [`RIM_NSRC-1:0]        clr;
    rim_mode_type                mode [`RIM_NSRC];

    ////////////////////////////////////////////////////////////////////////////
    // trigger detectors

    genvar g;
    generate
        for (g = 0; g < `RIM_NSRC; g = g + 1) begin : g_src
            if (g < `RIM_NMODE) begin : g_sel
                // four sources take their trigger from the mode register
                assign mode[g] = rim_mode_type'(trig_r[2*g +: 2]);
            end else begin : g_fix
                // sources without a mode field keep the default rising edge
                assign mode[g] = RIM_RISE;
            end
            rim_trigger u_trig (
                .clk  (MCLK),
                .rst  (RESET),
                .cond (RX_COND[g]),
                .mode (mode[g]),
                .evt  (evt[g])
            );
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////
    // register writes, sticky status and interrupt

    always_comb begin
        en_nxt   = en_r;
        trig_nxt = trig_r;
        clr      = '0;
        if (wr.en) begin
            case (wr.idx)
                `RIM_IDX_EN_ONE:   en_nxt[7:0] = wr.data;
                `RIM_IDX_EN_TWO:   en_nxt[`RIM_SRC_SLIP] = wr.data[0];
                `RIM_IDX_TRIG_ONE: trig_nxt = wr.data;
                `RIM_IDX_CLR_ONE:  clr[7:0] = wr.data;
                `RIM_IDX_CLR_TWO:  clr[`RIM_SRC_SLIP] = wr.data[0];
                default:           clr = '0;
            endcase
        end
        // a new event in the clearing cycle survives the clear
        sts_nxt = (sts_r & ~clr) | evt;
        irq_nxt = |(sts_nxt & en_nxt);
    end

    always_ff @(posedge MCLK or posedge RESET) begin
        if (RESET) begin
            en_r   <= `RIM_EN_RST;
            trig_r <= `RIM_TRIG_RST;
            sts_r  <= `RIM_STS_RST;
            irq_r  <= 1'b0;
        end else begin
            en_r   <= en_nxt;
            trig_r <= trig_nxt;
            sts_r  <= sts_nxt;
            irq_r  <= irq_nxt;
        end
    end

    assign RECV_IRQ = irq_r;

    ////////////////////////////////////////////////////////////////////////////
    // read mux; clear registers are write-only and read zero

    always_comb begin
        case (rd_idx)
            `RIM_IDX_EN_ONE:   rd_data = en_r[7:0];
            `RIM_IDX_EN_TWO:   rd_data = {7'h00, en_r[`RIM_SRC_SLIP]};
            `RIM_IDX_TRIG_ONE: rd_data = trig_r;
            `RIM_IDX_STS_ONE:  rd_data = sts_r[7:0];
            `RIM_IDX_STS_TWO:  rd_data = {7'h00, sts_r[`RIM_SRC_SLIP]};
            `RIM_IDX_COND:     rd_data = RX_COND[7:0];
            default:           rd_data = 8'h00;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////
    // checks

    default clocking cb @(posedge MCLK);
    endclocking
    default disable iff (RESET);

    property p_cscrc_gate;
        (en_r == 9'h080 && sts_r[`RIM_SRC_CSCRC]) |-> RECV_IRQ;
    endproperty
    a_cscrc_gate: assert property (p_cscrc_gate) else $error("enabled crc status gave no irq");

    property p_parity_mask;
        (sts_r == (9'h001 << `RIM_SRC_PARITY) && !en_r[`RIM_SRC_PARITY]) |-> !RECV_IRQ;
    endproperty
    a_parity_mask: assert property (p_parity_mask) else $error("masked parity status reached irq");

    property p_slip_gate;
        (en_r[`RIM_SRC_SLIP] && sts_r[`RIM_SRC_SLIP]) |-> RECV_IRQ;
    endproperty
    a_slip_gate: assert property (p_slip_gate) else $error("enabled slip status gave no irq");

    property p_qchg_rise;
        (mode[`RIM_SRC_QCHG] == RIM_RISE && $rose(RX_COND[`RIM_SRC_QCHG])) |=> sts_r[`RIM_SRC_QCHG];
    endproperty
    a_qchg_rise: assert property (p_qchg_rise) else $error("subcode change rise not caught");

    property p_lock_fall;
        (trig_r[5:4] == 2'h1 && $fell(RX_COND[`RIM_SRC_LOCK])) |=> sts_r[`RIM_SRC_LOCK];
    endproperty
    a_lock_fall: assert property (p_lock_fall) else $error("lock loss fall not caught");

    property p_qcrc_level;
        (trig_r[3:2] == 2'h2 && RX_COND[`RIM_SRC_QCRC]) [*2] |=> sts_r[`RIM_SRC_QCRC];
    endproperty
    a_qcrc_level: assert property (p_qcrc_level) else $error("level request not held");

    property p_xfer_fall_only;
        (mode[`RIM_SRC_XFER] == RIM_FALL && !sts_r[`RIM_SRC_XFER] && !$fell(RX_COND[`RIM_SRC_XFER]))
            |=> !sts_r[`RIM_SRC_XFER];
    endproperty
    a_xfer_fall_only: assert property (p_xfer_fall_only) else $error("falling mode set on non-edge");

    property p_no_enable;
        (en_r == `RIM_EN_RST) |-> !RECV_IRQ;
    endproperty
    a_no_enable: assert property (p_no_enable) else $error("irq with all sources masked");

    property p_irq_cause;
        RECV_IRQ |-> (|(sts_r & en_r));
    endproperty
    a_irq_cause: assert property (p_irq_cause) else $error("irq without enabled status");

    property p_irq_follow;
        (|(sts_r & en_r)) |-> RECV_IRQ;
    endproperty
    a_irq_follow: assert property (p_irq_follow) else $error("enabled status gave no irq");

    property p_valid_gate;
        (en_r[`RIM_SRC_VALID] && sts_r[`RIM_SRC_VALID]) |-> RECV_IRQ;
    endproperty
    a_valid_gate: assert property (p_valid_gate) else $error("enabled validity status gave no irq");

    property p_biph_gate;
        (en_r[`RIM_SRC_BIPH] && sts_r[`RIM_SRC_BIPH]) |-> RECV_IRQ;
    endproperty
    a_biph_gate: assert property (p_biph_gate) else $error("enabled biphase status gave no irq");

    property p_change_gate;
        (en_r[`RIM_SRC_QCHG] && sts_r[`RIM_SRC_QCHG]) |-> RECV_IRQ;
    endproperty
    a_change_gate: assert property (p_change_gate) else $error("enabled change status gave no irq");

    property p_lock_gate;
        (en_r[`RIM_SRC_LOCK] && sts_r[`RIM_SRC_LOCK]) |-> RECV_IRQ;
    endproperty
    a_lock_gate: assert property (p_lock_gate) else $error("enabled lock loss status gave no irq");

    property p_subcrc_gate;
        (en_r[`RIM_SRC_QCRC] && sts_r[`RIM_SRC_QCRC]) |-> RECV_IRQ;
    endproperty
    a_subcrc_gate: assert property (p_subcrc_gate) else $error("enabled subcode crc status gave no irq");

    property p_xfer_gate;
        (en_r[`RIM_SRC_XFER] && sts_r[`RIM_SRC_XFER]) |-> RECV_IRQ;
    endproperty
    a_xfer_gate: assert property (p_xfer_gate) else $error("enabled transfer status gave no irq");

    property p_change_level;
        (mode[`RIM_SRC_QCHG] == RIM_LEVEL && RX_COND[`RIM_SRC_QCHG]) |=> sts_r[`RIM_SRC_QCHG];
    endproperty
    a_change_level: assert property (p_change_level) else $error("subcode change level not caught");

    property p_lock_level;
        (mode[`RIM_SRC_LOCK] == RIM_LEVEL && RX_COND[`RIM_SRC_LOCK]) |=> sts_r[`RIM_SRC_LOCK];
    endproperty
    a_lock_level: assert property (p_lock_level) else $error("lock loss level not caught");

    property p_subcrc_fall;
        (mode[`RIM_SRC_QCRC] == RIM_FALL && $fell(RX_COND[`RIM_SRC_QCRC])) |=> sts_r[`RIM_SRC_QCRC];
    endproperty
    a_subcrc_fall: assert property (p_subcrc_fall) else $error("subcode crc fall not caught");

    property p_xfer_rise;
        (mode[`RIM_SRC_XFER] == RIM_RISE && $rose(RX_COND[`RIM_SRC_XFER])) |=> sts_r[`RIM_SRC_XFER];
    endproperty
    a_xfer_rise: assert property (p_xfer_rise) else $error("transfer rise not caught");

    property p_xfer_level;
        (mode[`RIM_SRC_XFER] == RIM_LEVEL && RX_COND[`RIM_SRC_XFER]) |=> sts_r[`RIM_SRC_XFER];
    endproperty
    a_xfer_level: assert property (p_xfer_level) else $error("transfer level not caught");
endmodule : rim_top

// *** rim_top_test.sv ***
// self-checking testbench for the receiver interrupt mask and mode block
`timescale 1ns/1ps
`include "rim_cfg.svh"
module rim_top_test;
    import rim_pkg::*;

    logic                 mclk;
    logic                 reset;
    logic [`RIM_AW-1:0]   awaddr;
    logic                 awvalid;
    logic                 awready;
    logic [31:0]          wdata;
    logic [3:0]           wstrb;
    logic                 wvalid;
    logic                 wready;
    logic [1:0]           bresp;
    logic                 bvalid;
    logic                 bready;
    logic [`RIM_AW-1:0]   araddr;
    logic                 arvalid;
    logic                 arready;
    logic [31:0]          rdata;
    logic [1:0]           rresp;
    logic                 rvalid;
    logic                 rready;
    logic [`RIM_NSRC-1:0] rx_cond;
    logic                 recv_irq;
    int                   err_count;
    int                   checked;
    int                   cycles;
    logic [7:0]           sts_idx;
    logic [7:0]           en_idx;
    logic [7:0]           clr_idx;
    logic [7:0]           bitv;
    logic                 ok;

    rim_top uut (
        .MCLK     (mclk),
        .RESET    (reset),
        .AWADDR   (awaddr),
        .AWVALID  (awvalid),
        .AWREADY  (awready),
        .WDATA    (wdata),
        .WSTRB    (wstrb),
        .WVALID   (wvalid),
        .WREADY   (wready),
        .BRESP    (bresp),
        .BVALID   (bvalid),
        .BREADY   (bready),
        .ARADDR   (araddr),
        .ARVALID  (arvalid),
        .ARREADY  (arready),
        .RDATA    (rdata),
        .RRESP    (rresp),
        .RVALID   (rvalid),
        .RREADY   (rready),
        .RX_COND  (rx_cond),
        .RECV_IRQ (recv_irq)
    );

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            err_count++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic test_done;
        if (err_count == 0 && checked > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : test_done

    // a hang anywhere in the handshakes ends here
    initial begin
        cycles = 0;
        forever begin
            @(posedge mclk);
            cycles++;
            if (cycles > 20000) begin
                err_count++;
                test_done();
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // address and data offered together, each dropped once taken
    task automatic wr(input logic [7:0] idx, input logic [7:0] val, input logic [1:0] exp_resp);
        logic aw_done;
        logic w_done;
        aw_done = 1'b0;
        w_done  = 1'b0;
        @(posedge mclk);
        awaddr  <= {idx, 2'b00};
        wdata   <= {24'h000000, val};
        awvalid <= 1'b1;
        wvalid  <= 1'b1;
        bready  <= 1'b1;
        while (!(aw_done && w_done)) begin
            @(posedge mclk);
            if (awvalid && awready) begin
                aw_done = 1'b1;
                awvalid <= 1'b0;
            end
            if (wvalid && wready) begin
                w_done = 1'b1;
                wvalid <= 1'b0;
            end
        end
        do @(posedge mclk); while (bvalid !== 1'b1);
        bready <= 1'b0;
        check({30'h0, bresp}, {30'h0, exp_resp});
    endtask : wr

    task automatic rd(input logic [7:0] idx, input logic [7:0] exp, input logic [1:0] exp_resp);
        @(posedge mclk);
        araddr  <= {idx, 2'b00};
        arvalid <= 1'b1;
        rready  <= 1'b1;
        do @(posedge mclk); while (arready !== 1'b1);
        arvalid <= 1'b0;
        do @(posedge mclk); while (rvalid !== 1'b1);
        rready <= 1'b0;
        check(rdata, {24'h000000, exp});
        check({30'h0, rresp}, {30'h0, exp_resp});
    endtask : rd

    // three edges let the change be seen, detected and latched
    task automatic set_cond(input int i, input logic v);
        @(posedge mclk);
        rx_cond[i] <= v;
        repeat (3) @(posedge mclk);
    endtask : set_cond

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        err_count = 0;
        checked   = 0;
        reset     = 1'b1;
        awaddr    = '0;
        awvalid   = 1'b0;
        wdata     = 32'h00000000;
        wstrb     = 4'hF;
        wvalid    = 1'b0;
        bready    = 1'b0;
        araddr    = '0;
        arvalid   = 1'b0;
        rready    = 1'b0;
        rx_cond   = '0;
        repeat (6) @(posedge mclk);
        reset <= 1'b0;
        // reset values, unmapped and write-only places
        rd(`RIM_IDX_EN_ONE, 8'h00, `RIM_RESP_OKAY);
        rd(`RIM_IDX_EN_TWO, 8'h00, `RIM_RESP_OKAY);
        rd(`RIM_IDX_TRIG_ONE, 8'h00, `RIM_RESP_OKAY);
        rd(8'h40, 8'h00, `RIM_RESP_SLVERR);
        wr(8'h40, 8'hFF, `RIM_RESP_SLVERR);
        rd(`RIM_IDX_CLR_ONE, 8'h00, `RIM_RESP_OKAY);
        // status is read-only: a write is answered but changes nothing
        wr(`RIM_IDX_STS_ONE, 8'hFF, `RIM_RESP_OKAY);
        rd(`RIM_IDX_STS_ONE, 8'h00, `RIM_RESP_OKAY);
        wr(`RIM_IDX_TRIG_ONE, 8'hE4, `RIM_RESP_OKAY);
        rd(`RIM_IDX_TRIG_ONE, 8'hE4, `RIM_RESP_OKAY);
        wstrb <= 4'hE;
        wr(`RIM_IDX_TRIG_ONE, 8'h00, `RIM_RESP_OKAY);
        wstrb <= 4'hF;
        rd(`RIM_IDX_TRIG_ONE, 8'hE4, `RIM_RESP_OKAY);
        wr(`RIM_IDX_TRIG_ONE, 8'h00, `RIM_RESP_OKAY);
        wr(`RIM_IDX_EN_TWO, 8'hFF, `RIM_RESP_OKAY);
        rd(`RIM_IDX_EN_TWO, 8'h01, `RIM_RESP_OKAY);
        wr(`RIM_IDX_EN_TWO, 8'h00, `RIM_RESP_OKAY);
        // each source: status latches while masked, irq follows its enable
        for (int i = 0; i < `RIM_NSRC; i++) begin
            sts_idx = (i == `RIM_SRC_SLIP) ? `RIM_IDX_STS_TWO : `RIM_IDX_STS_ONE;
            en_idx  = (i == `RIM_SRC_SLIP) ? `RIM_IDX_EN_TWO : `RIM_IDX_EN_ONE;
            clr_idx = (i == `RIM_SRC_SLIP) ? `RIM_IDX_CLR_TWO : `RIM_IDX_CLR_ONE;
            bitv    = (i == `RIM_SRC_SLIP) ? 8'h01 : (8'h01 << i);
            set_cond(i, 1'b1);
            rd(sts_idx, bitv, `RIM_RESP_OKAY);
            check({31'h0, recv_irq}, 32'h0);
            wr(en_idx, bitv, `RIM_RESP_OKAY);
            check({31'h0, recv_irq}, 32'h1);
            wr(clr_idx, bitv, `RIM_RESP_OKAY);
            check({31'h0, recv_irq}, 32'h0);
            rd(sts_idx, 8'h00, `RIM_RESP_OKAY);
            set_cond(i, 1'b0);
            wr(en_idx, 8'h00, `RIM_RESP_OKAY);
        end
        // two sources pending: irq drops only when both are cleared
        set_cond(0, 1'b1);
        set_cond(8, 1'b1);
        rd(`RIM_IDX_COND, 8'h01, `RIM_RESP_OKAY);
        wr(`RIM_IDX_EN_ONE, 8'h01, `RIM_RESP_OKAY);
        wr(`RIM_IDX_EN_TWO, 8'h01, `RIM_RESP_OKAY);
        wr(`RIM_IDX_CLR_ONE, 8'h01, `RIM_RESP_OKAY);
        check({31'h0, recv_irq}, 32'h1);
        wr(`RIM_IDX_CLR_TWO, 8'h01, `RIM_RESP_OKAY);
        check({31'h0, recv_irq}, 32'h0);
        set_cond(0, 1'b0);
        set_cond(8, 1'b0);
        wr(`RIM_IDX_EN_ONE, 8'h00, `RIM_RESP_OKAY);
        wr(`RIM_IDX_EN_TWO, 8'h00, `RIM_RESP_OKAY);
        // every defined trigger code on every moded source; the reserved code is written only by the 8'hE4 readback above
        for (int s = 0; s < `RIM_NMODE; s++) begin
            bitv = 8'h01 << s;
            for (int c = 0; c < 3; c++) begin
                wr(`RIM_IDX_TRIG_ONE, 8'(c << (2 * s)), `RIM_RESP_OKAY);
                wr(`RIM_IDX_CLR_ONE, 8'hFF, `RIM_RESP_OKAY);
                set_cond(s, 1'b1);
                ok = (c == 0 || c == 2);
                rd(`RIM_IDX_STS_ONE, ok ? bitv : 8'h00, `RIM_RESP_OKAY);
                wr(`RIM_IDX_CLR_ONE, bitv, `RIM_RESP_OKAY);
                ok = (c == 2);
                rd(`RIM_IDX_STS_ONE, ok ? bitv : 8'h00, `RIM_RESP_OKAY);
                set_cond(s, 1'b0);
                ok = (c == 1 || c == 2);
                rd(`RIM_IDX_STS_ONE, ok ? bitv : 8'h00, `RIM_RESP_OKAY);
                check({31'h0, recv_irq}, 32'h0);
            end
        end
        test_done();
    end
endmodule : rim_top_test

// *** rim_trigger.sv ***
// per-source trigger detector: rising, falling or level
`timescale 1ns/1ps
`include "rim_cfg.svh"
module rim_trigger (
    // clock and reset
    input  wire logic              clk,
    input  wire logic              rst,
    // condition and selected mode
    input  wire logic              cond,
    input  rim_pkg::rim_mode_type  mode,
    // one-cycle event, or held request in level mode
    output logic                   evt
);
    import rim_pkg::*;

    logic prev_r;
    logic prev_nxt;

    always_comb begin
        prev_nxt = cond;
        case (mode)
            RIM_RISE:  evt = cond & ~prev_r;
            RIM_FALL:  evt = ~cond & prev_r;
            RIM_LEVEL: evt = cond;
            // reserved code: quiet rather than guess a meaning
            default:   evt = 1'b0;
        endcase
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            prev_r <= 1'b0;
        end else begin
            prev_r <= prev_nxt;
        end
    end
endmodule : rim_trigger
